/* File: hdl/lfrc_pkg.sv */
/*
  Package for the low-frequency RC oscillator control block: register
  offsets, alias windows, field positions, reset values and the state record.
  Assumes a 32-bit APB slave port with byte addresses and aligned words.
*/
package lfrc_pkg;

  // ****************************************************************
  // Register offsets, low 12 address bits
  // ****************************************************************
  localparam logic [11:0] OFS_MODULE_VERSION = 12'h000;
  localparam logic [11:0] OFS_OSC_CONTROL = 12'h004;
  localparam logic [11:0] OFS_OSC_STATUS = 12'h008;
  localparam logic [11:0] OFS_FREQ_CALIBRATION = 12'h00C;
  localparam logic [11:0] OFS_IRQ_FLAGS = 12'h014;
  localparam logic [11:0] OFS_IRQ_ENABLES = 12'h018;
  localparam logic [11:0] OFS_SYNC_BUSY_FLAGS = 12'h01C;
  localparam logic [11:0] OFS_CONFIG_LOCK_KEY = 12'h020;

  // ****************************************************************
  // Alias windows selected by address bits 13:12
  // ****************************************************************
  typedef enum logic [1:0] {
    WIN_NORMAL,
    WIN_SET,
    WIN_CLEAR,
    WIN_TOGGLE
  } lfrc_win_e;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_FORCE_ON = 0;
  localparam int BIT_ON_REQUEST_DISABLE = 1;
  localparam int BIT_STAT_READY = 0;
  localparam int BIT_STAT_CORE_ENABLED = 16;
  localparam int BIT_STAT_LOCKED = 31;
  localparam int BIT_READY_FLAG = 0;
  localparam int BIT_RISE_EDGE_FLAG = 1;
  localparam int BIT_FALL_EDGE_FLAG = 2;
  localparam int BIT_CAL_SYNC_PENDING = 0;
  localparam int TRIM_W = 8;
  localparam int KEY_W = 16;

  // ****************************************************************
  // Reset values and constants
  // ****************************************************************
  localparam logic [7:0] RST_FREQ_TRIM = 8'hA5;
  localparam logic [15:0] UNLOCK_KEY = 16'h2603;
  localparam logic [31:0] RST_REVISION = 32'h0000_0101;
  localparam int RST_QUAL_EDGES = 4;
  localparam int CLK_PROPAGATE_CYCLES = 2;

  // ****************************************************************
  // Complete state of the controller
  // ****************************************************************
  typedef struct packed {
    logic forceOn;
    logic onRequestDisable;
    logic locked;
    logic [7:0] freqTrimA;
    logic [7:0] freqTrimOsc;
    logic calSyncPending;
    logic [2:0] irqFlags;
    logic [2:0] irqEnables;
    logic [7:0] qualCount;
    logic ready;
    logic oscPrev;
    logic [1:0] clkPipe;
    logic wakeup;
    logic preadyOut;
    logic pslverrOut;
    logic [31:0] prdataOut;
  } lfrc_state_s;

endpackage

/* File: hdl/lfrc_ctrl.sv */
/*
  Control wrapper for a 32.768 kHz RC oscillator: on-request enabling,
  start-up qualification, trim synchronisation, configuration lock,
  ready and edge flags with deep sleep wakeup, APB register slave.
  Assumes the oscillator clock and all requests arrive synchronous to clk_sys.
*/
module lfrc_ctrl #(
  parameter logic [31:0] MODULE_REVISION = lfrc_pkg::RST_REVISION, // Arbitrary value
  parameter int QUAL_EDGES = lfrc_pkg::RST_QUAL_EDGES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clockRequest,
  input wire logic oscClk,
  input wire logic prodTrimLoad,
  input wire logic [7:0] prodTrim,
  output logic coreEnable,
  output logic [7:0] freqTrimOsc,
  output logic clkToCmu,
  output logic wakeupReq
);

  // ****************************************************************
  // State
  // ****************************************************************
  lfrc_pkg::lfrc_state_s s_q;
  lfrc_pkg::lfrc_state_s s_d;

  logic [11:0] ofs;
  lfrc_pkg::lfrc_win_e win;
  logic setupPhase;
  logic wrAccept;
  logic edgeReq;
  logic enableNow;
  logic oscRise;
  logic oscFall;
  logic mapped;
  logic lockable;
  logic [31:0] readMux;
  logic [2:0] hwSet;

  assign ofs = paddr[11:0];
  assign win = lfrc_pkg::lfrc_win_e'(paddr[13:12]);
  assign setupPhase = psel & ~penable;
  assign wrAccept = psel & penable & s_q.preadyOut & pwrite & ~s_q.pslverrOut;
  assign edgeReq = s_q.irqEnables[lfrc_pkg::BIT_RISE_EDGE_FLAG]
    | s_q.irqEnables[lfrc_pkg::BIT_FALL_EDGE_FLAG];
  assign enableNow = s_q.forceOn
    | (~s_q.onRequestDisable & (clockRequest | edgeReq));
  assign oscRise = oscClk & ~s_q.oscPrev;
  assign oscFall = ~oscClk & s_q.oscPrev;
  assign lockable = (ofs == lfrc_pkg::OFS_FREQ_CALIBRATION)
    | (ofs == lfrc_pkg::OFS_OSC_CONTROL);

  // Alias write: plain, set, clear or toggle
  function automatic logic [31:0] alias_wr(input logic [1:0] w, input logic [31:0] old,
                                           input logic [31:0] dat);
    logic [31:0] r;
    r = dat;
    case (w)
      2'd1: r = old | dat;
      2'd2: r = old & ~dat;
      2'd3: r = old ^ dat;
      default: r = dat;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb begin
    readMux = 32'h0000_0000;
    mapped = 1'b1;
    case (ofs)
      lfrc_pkg::OFS_MODULE_VERSION: readMux = MODULE_REVISION;
      lfrc_pkg::OFS_OSC_CONTROL: begin
        readMux[lfrc_pkg::BIT_FORCE_ON] = s_q.forceOn;
        readMux[lfrc_pkg::BIT_ON_REQUEST_DISABLE] = s_q.onRequestDisable;
      end
      lfrc_pkg::OFS_OSC_STATUS: begin
        readMux[lfrc_pkg::BIT_STAT_LOCKED] = s_q.locked;
        readMux[lfrc_pkg::BIT_STAT_CORE_ENABLED] = enableNow;
        readMux[lfrc_pkg::BIT_STAT_READY] = s_q.ready;
      end
      lfrc_pkg::OFS_FREQ_CALIBRATION: readMux[7:0] = s_q.freqTrimA;
      lfrc_pkg::OFS_IRQ_FLAGS: readMux[2:0] = s_q.irqFlags;
      lfrc_pkg::OFS_IRQ_ENABLES: readMux[2:0] = s_q.irqEnables;
      lfrc_pkg::OFS_SYNC_BUSY_FLAGS:
        readMux[lfrc_pkg::BIT_CAL_SYNC_PENDING] = s_q.calSyncPending;
      lfrc_pkg::OFS_CONFIG_LOCK_KEY: readMux = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [31:0] nv;
    nv = 32'h0000_0000;
    hwSet = 3'b000;
    s_d = s_q;
    s_d.oscPrev = oscClk;

    // Start-up qualification counts oscillator rising edges
    if (!enableNow) begin
      s_d.qualCount = 8'h00;
      s_d.ready = 1'b0;
    end else if (!s_q.ready && oscRise) begin
      if (32'(s_q.qualCount) + 32'd1 >= 32'(QUAL_EDGES)) begin
        s_d.ready = 1'b1;
        hwSet[lfrc_pkg::BIT_READY_FLAG] = 1'b1;
      end else begin
        s_d.qualCount = s_q.qualCount + 8'h01;
      end
    end

    // Clock gated by ready, two register stages to the CMU side
    s_d.clkPipe = {s_q.clkPipe[0], oscClk & s_q.ready};

    // Edge flags only while an edge enable is on
    if (edgeReq && s_q.ready) begin
      hwSet[lfrc_pkg::BIT_RISE_EDGE_FLAG] = oscRise;
      hwSet[lfrc_pkg::BIT_FALL_EDGE_FLAG] = oscFall;
    end

    // Trim transfer into the oscillator side on its rising edge, or at once while the core is disabled
    if (s_q.calSyncPending && (oscRise || !enableNow)) begin
      s_d.freqTrimOsc = s_q.freqTrimA;
      s_d.calSyncPending = 1'b0;
    end

    // Production trim load at boot
    if (prodTrimLoad) begin
      s_d.freqTrimA = prodTrim;
      s_d.calSyncPending = 1'b1;
    end

    // APB: answer in the access phase following setup
    s_d.preadyOut = setupPhase;
    if (setupPhase) begin
      s_d.prdataOut = pwrite ? 32'h0000_0000 : readMux;
      s_d.pslverrOut = ~mapped | (pwrite & lockable & s_q.locked);
    end

    if (wrAccept) begin
      case (ofs)
        lfrc_pkg::OFS_OSC_CONTROL: begin
          nv = alias_wr(win,
                        {30'h0, s_q.onRequestDisable, s_q.forceOn}, pwdata);
          s_d.forceOn = nv[lfrc_pkg::BIT_FORCE_ON];
          s_d.onRequestDisable = nv[lfrc_pkg::BIT_ON_REQUEST_DISABLE];
        end
        lfrc_pkg::OFS_FREQ_CALIBRATION: begin
          nv = alias_wr(win, {24'h0, s_q.freqTrimA}, pwdata);
          s_d.freqTrimA = nv[7:0];
          s_d.calSyncPending = 1'b1;
        end
        lfrc_pkg::OFS_IRQ_FLAGS: begin
          nv = alias_wr(win, {29'h0, s_q.irqFlags}, pwdata);
          s_d.irqFlags = nv[2:0];
        end
        lfrc_pkg::OFS_IRQ_ENABLES: begin
          nv = alias_wr(win, {29'h0, s_q.irqEnables}, pwdata);
          s_d.irqEnables = nv[2:0];
        end
        lfrc_pkg::OFS_CONFIG_LOCK_KEY:
          s_d.locked = (pwdata[15:0] != lfrc_pkg::UNLOCK_KEY);
        default: s_d.locked = s_q.locked;
      endcase
    end

    // Hardware set wins over a software clear
    s_d.irqFlags = s_d.irqFlags | hwSet;
    s_d.wakeup = |(s_d.irqFlags & s_d.irqEnables);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.freqTrimA <= lfrc_pkg::RST_FREQ_TRIM;
      s_q.freqTrimOsc <= lfrc_pkg::RST_FREQ_TRIM;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = s_q.prdataOut;
  assign pready = s_q.preadyOut;
  assign pslverr = s_q.preadyOut & s_q.pslverrOut;
  assign coreEnable = enableNow;
  assign freqTrimOsc = s_q.freqTrimOsc;
  assign clkToCmu = s_q.clkPipe[1];
  assign wakeupReq = s_q.wakeup;

endmodule // lfrc_ctrl

/* File: testbench/lfrc_ctrl_assertions.sv */
/*
  Port checker for lfrc_ctrl, bound onto every instance.
  Assumes one clock domain and a synchronous active low reset.
*/
module lfrc_ctrl_assertions #(
  parameter logic [31:0] MODULE_REVISION = 32'h0000_0000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic oscClk,
  input wire logic coreEnable,
  input wire logic [7:0] freqTrimOsc,
  input wire logic clkToCmu,
  input wire logic wakeupReq
);
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_rd(logic [11:0] ofs);
    psel && !penable && !pwrite && paddr[11:0] == ofs;
  endsequence
  sequence s_key_wr;
    psel && penable && pready && pwrite && paddr[11:0] == 12'h020;
  endsequence
  a_ready_timing: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_quiet: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  a_version_read: assert property (s_rd(12'h000) |=> prdata == MODULE_REVISION)
    else $error("revision read wrong");
  a_enable_status: assert property (s_rd(12'h008) |=> prdata[16] == $past(coreEnable))
    else $error("core enabled status wrong");
  a_unmapped_err: assert property (s_rd(12'h010) |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_clk_delay: assert property (clkToCmu |-> $past(oscClk, 2))
    else $error("clock out not two cycles late");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=>
    !pready && !wakeupReq && !clkToCmu && freqTrimOsc == 8'hA5)
    else $error("reset state wrong");
  a_unlock_key: assert property (
    (s_key_wr and (pwdata[15:0] == 16'h2603)) ##2 s_rd(12'h008) |=> !prdata[31])
    else $error("unlock key not honoured");
  a_lock_key: assert property (
    (s_key_wr and (pwdata[15:0] != 16'h2603)) ##2 s_rd(12'h008) |=> prdata[31])
    else $error("lock status not shown");
endmodule // lfrc_ctrl_assertions

bind lfrc_ctrl lfrc_ctrl_assertions #(.MODULE_REVISION(MODULE_REVISION)) u_chk (
  .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .oscClk, .coreEnable, .freqTrimOsc, .clkToCmu, .wakeupReq);

/* File: testbench/lfrc_cmu_model.sv */
/*
  Clock requester and oscillator stand-in on the far side of lfrc_ctrl.
  Assumes the oscillator runs only while the core enable is high.
*/
module lfrc_cmu_model #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic want,
  input wire logic coreEnable,
  output logic clockRequest = 1'b0,
  output logic oscClk = 1'b0
);
  int cnt = 0;
  always @(posedge clk_sys) begin
    clockRequest <= rstn && want;
    cnt <= (coreEnable && cnt < HALF - 1) ? cnt + 1 : 0;
    // Stopped core gives a low clock
    oscClk <= coreEnable ? (cnt == HALF - 1 ? !oscClk : oscClk) : 1'b0;
  end
endmodule // lfrc_cmu_model

/* File: testbench/test_lfrc_ctrl.sv */
/*
  Self-checking bench for lfrc_ctrl: APB master, register model, scenarios.
  Assumes lfrc_cmu_model as requester and the bound port checker.
*/
module test_lfrc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] REV = 32'h0000_0203; // Arbitrary revision value
  logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, clockRequest, oscClk, coreEnable, clkToCmu, wakeupReq;
  logic prodTrimLoad = 1'b0, want = 1'b0, err;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] prodTrim = 8'h0, freqTrimOsc, mTrim;
  logic [11:0] ofs [5] = '{12'h008, 12'h00C, 12'h014, 12'h018, 12'h01C};
  logic [31:0] rv [5] = '{32'h0, 32'h0000_00A5, 32'h0, 32'h0, 32'h0};
  int failures = 0, check_count = 0;
  integer seed = 32'h9a765fc5;

  lfrc_ctrl #(.MODULE_REVISION(REV), .QUAL_EDGES(2)) u_dut (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .clockRequest, .oscClk, .prodTrimLoad, .prodTrim, .coreEnable,
    .freqTrimOsc, .clkToCmu, .wakeupReq);
  lfrc_cmu_model u_cmu (.clk_sys, .rstn, .want, .coreEnable, .clockRequest, .oscClk);

  initial forever #10 clk_sys = !clk_sys;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input logic [13:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(err, e);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 200 && clkToCmu !== 1'b1; i++) @(posedge clk_sys);
  endtask
  task automatic settle;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, 14'h001C, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd, 32'h0);
    chk(freqTrimOsc, mTrim);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk({i[1:0], 12'h000}, REV, 1'b0);
    for (int i = 0; i < 5; i++) rdchk({2'b00, ofs[i]}, rv[i], 1'b0);
    rdchk(14'h0010, 32'h0, 1'b1);
    mTrim = 8'($random(seed));
    prodTrim <= mTrim;
    prodTrimLoad <= 1'b1;
    @(posedge clk_sys);
    prodTrimLoad <= 1'b0;
    rdchk(14'h000C, {24'h0, mTrim}, 1'b0);
    want <= 1'b1;
    wait_ready();
    rdchk(14'h0008, 32'h0001_0001, 1'b0);
    rdchk(14'h0014, 32'h0000_0001, 1'b0);
    chk(wakeupReq, 1'b0);
    apb(1'b1, 14'h2014, 32'h0000_0001);
    want <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rdchk(14'h0008, 32'h0, 1'b0);
    apb(1'b1, 14'h1004, 32'h0000_0001);
    wait_ready();
    rdchk(14'h0008, 32'h0001_0001, 1'b0);
    mTrim = 8'($random(seed));
    apb(1'b1, 14'h000C, {24'h0, mTrim});
    settle();
    apb(1'b1, 14'h300C, 32'h0000_00FF);
    mTrim = mTrim ^ 8'hFF;
    settle();
    apb(1'b1, 14'h0018, 32'h0000_0007);
    repeat (20) @(posedge clk_sys);
    rdchk(14'h0014, 32'h0000_0007, 1'b0);
    chk(wakeupReq, 1'b1);
    apb(1'b1, 14'h0018, 32'h0);
    apb(1'b1, 14'h2014, 32'h0000_0007);
    repeat (20) @(posedge clk_sys);
    rdchk(14'h0014, 32'h0, 1'b0);
    chk(wakeupReq, 1'b0);
    apb(1'b1, 14'h2004, 32'h0000_0001);
    apb(1'b1, 14'h0020, 32'h0);
    rdchk(14'h0008, 32'h8000_0000, 1'b0);
    apb(1'b1, 14'h000C, {24'h0, ~mTrim});
    chk(err, 1'b1);
    rdchk(14'h000C, {24'h0, mTrim}, 1'b0);
    apb(1'b1, 14'h1020, 32'h0000_2603);
    rdchk(14'h0008, 32'h0, 1'b0);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule // test_lfrc_ctrl
